// ===== core/lcx_pkg.sv
// shared constants and types for the logical and compare execution unit
package lcx_pkg;

   // ********************************
   // opcodes
   // ********************************
   localparam logic [7:0] OP_XOR_HALF = 8'h33;
   localparam logic [7:0] OP_XOR_BYTE = 8'h23;
   localparam logic [7:0] OP_XOR_STOR = 8'h65;
   localparam logic [7:0] OP_COMPL = 8'h3b;
   localparam logic [7:0] OP_CMP_AND = 8'h34;
   localparam logic [7:0] OP_CMP_WORD = 8'h17;
   localparam logic [7:0] OP_CMP_HALF = 8'h10;
   localparam logic [7:0] OP_CMP_BYTE = 8'h0b;

   // ********************************
   // mode field encodings
   // ********************************
   localparam logic [1:0] M_MEM = 2'h0;
   localparam logic [1:0] M_A = 2'h1;
   localparam logic [1:0] M_B = 2'h2;
   localparam logic [1:0] M_D = 2'h3;
   localparam logic [1:0] M_LEFT = 2'h1;
   localparam logic [1:0] M_RIGHT = 2'h2;
   localparam logic [1:0] M_RIGHT_SX = 2'h3;

   // ********************************
   // condition indicator codes
   // ********************************
   localparam logic [1:0] CC_RESET = 2'h0;
   localparam logic [1:0] CC_ONE = 2'h1;
   localparam logic [1:0] CC_TWO = 2'h2;
   localparam logic [1:0] CC_THREE = 2'h3;

   // ********************************
   // addresses and reset values
   // ********************************
   localparam logic [17:0] B_ACC_ADDR = 18'h00010;
   localparam logic [17:0] WORD_STEP = 18'h00004;
   localparam logic [31:0] ACC_A_RESET = 32'h0;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RD_B = 3'b001,
      S_RD_M0 = 3'b011,
      S_RD_M1 = 3'b010,
      S_EXEC = 3'b110,
      S_WR0 = 3'b111,
      S_WR1 = 3'b101
   } lcx_fsm_t;

   typedef struct packed {
      logic [7:0] op;
      logic [1:0] mode;
      logic cen;
      logic lit;
      logic [17:0] field;
      logic [17:0] ea;
   } lcx_instr_t;

   typedef struct packed {
      lcx_fsm_t fsm;
      lcx_instr_t ins;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] m0;
      logic [31:0] m1;
      logic [1:0] cc;
      logic busy;
      logic done;
      logic req;
      logic we;
      logic wr2;
      logic [17:0] addr;
      logic [17:0] wa1;
      logic [31:0] wdata;
      logic [31:0] wd1;
   } lcx_state_t;

   localparam lcx_state_t LCX_STATE_RST = '0;

endpackage

// ===== core/lcx_exec_unit.sv
// logical and compare execution unit with memory operand sequencing
`timescale 1ns/100ps
module lcx_exec_unit
   import lcx_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire lcx_instr_t instr_i,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [17:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [31:0] acc_a_o,
   output logic [1:0] cc_o,
   output logic busy_o,
   output logic done_o
);

   // ********************************
   // helper functions
   // ********************************
   function automatic logic is_word_op(input logic [7:0] op);
      return (op == OP_XOR_STOR) || (op == OP_COMPL) || (op == OP_CMP_AND) ||
         (op == OP_CMP_WORD);
   endfunction

   function automatic logic instr_valid(input lcx_instr_t i);
      case (i.op)
         OP_XOR_HALF: instr_valid = (i.mode != M_MEM);
         OP_XOR_BYTE: instr_valid = 1'b1;
         OP_XOR_STOR: instr_valid = (i.mode != M_MEM) && !i.lit;
         OP_COMPL: instr_valid = 1'b1;
         OP_CMP_AND: instr_valid = (i.mode != M_MEM) && i.cen;
         OP_CMP_WORD: instr_valid = (i.mode != M_MEM) && i.cen;
         OP_CMP_HALF: instr_valid = ((i.mode == M_LEFT) || (i.mode == M_RIGHT)) && i.cen;
         OP_CMP_BYTE: instr_valid = i.cen;
         default: instr_valid = 1'b0;
      endcase
   endfunction

   function automatic logic need_b(input lcx_instr_t i);
      return is_word_op(i.op) && i.mode[1];
   endfunction

   function automatic logic need_m(input lcx_instr_t i);
      return (i.op == OP_COMPL) ? (i.mode == M_MEM) : !i.lit;
   endfunction

   // narrow results ignore the upper word, which a complement sets to ones
   function automatic logic [1:0] cc_logic(input logic [63:0] v, input logic wide);
      logic [63:0] w;
      w = wide ? v : {32'h0, v[31:0]};
      return (wide ? (&v) : (&v[31:0])) ? CC_ONE : (w == 64'h0) ? CC_TWO : CC_THREE;
   endfunction

   function automatic logic [1:0] cmp_u(input logic [63:0] x, input logic [63:0] y);
      return (x < y) ? CC_ONE : (x == y) ? CC_TWO : CC_THREE;
   endfunction

   function automatic logic [7:0] byte_of(input logic [31:0] v, input logic [1:0] sel);
      logic [31:0] t;
      t = v << {sel, 3'b000};
      return t[31:24];
   endfunction

   // ********************************
   // state
   // ********************************
   lcx_state_t st_reg;
   lcx_state_t st_next;
   logic dbl;
   logic [63:0] sx64;
   logic [63:0] acc64;
   logic [63:0] opd64;
   logic [63:0] mem64;
   logic [63:0] r64;
   logic [15:0] op16;
   logic [7:0] op8;
   logic [15:0] ahalf;
   logic [31:0] newa;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      dbl = is_word_op(st_reg.ins.op) && (st_reg.ins.mode == M_D);
      sx64 = {{46{st_reg.ins.field[17]}}, st_reg.ins.field};
      acc64 = dbl ? {st_reg.a, st_reg.b} :
         {32'h0, (st_reg.ins.mode == M_A) ? st_reg.a : st_reg.b};
      mem64 = dbl ? {st_reg.m0, st_reg.m1} : {32'h0, st_reg.m0};
      opd64 = st_reg.ins.lit ? (dbl ? sx64 : {32'h0, sx64[31:0]}) : mem64;
      op16 = st_reg.ins.lit ? st_reg.ins.field[15:0] : st_reg.m0[15:0];
      op8 = st_reg.ins.lit ? st_reg.ins.field[7:0] : st_reg.m0[7:0];
      ahalf = (st_reg.ins.mode == M_LEFT) ? st_reg.a[31:16] : st_reg.a[15:0];
      r64 = 64'h0;
      newa = st_reg.a;
      case (st_reg.fsm)
         S_IDLE: begin
            if (start_i) begin
               st_next.ins = instr_i;
               st_next.busy = 1'b1;
               st_next.wr2 = 1'b0;
               if (!instr_valid(instr_i)) begin
                  st_next.busy = 1'b0;
                  st_next.done = 1'b1;
               end else if (need_b(instr_i)) begin
                  st_next.fsm = S_RD_B;
                  st_next.req = 1'b1;
                  st_next.we = 1'b0;
                  st_next.addr = B_ACC_ADDR;
               end else if (need_m(instr_i)) begin
                  st_next.fsm = S_RD_M0;
                  st_next.req = 1'b1;
                  st_next.we = 1'b0;
                  st_next.addr = instr_i.ea;
               end else begin
                  st_next.fsm = S_EXEC;
               end
            end
         end
         S_RD_B: begin
            if (mem_ack_i) begin
               st_next.b = mem_rdata_i;
               if (need_m(st_reg.ins)) begin
                  st_next.fsm = S_RD_M0;
                  st_next.addr = st_reg.ins.ea;
               end else begin
                  st_next.fsm = S_EXEC;
                  st_next.req = 1'b0;
               end
            end
         end
         S_RD_M0: begin
            if (mem_ack_i) begin
               st_next.m0 = mem_rdata_i;
               if (dbl) begin
                  st_next.fsm = S_RD_M1;
                  st_next.addr = st_reg.ins.ea + WORD_STEP;
               end else begin
                  st_next.fsm = S_EXEC;
                  st_next.req = 1'b0;
               end
            end
         end
         S_RD_M1: begin
            if (mem_ack_i) begin
               st_next.m1 = mem_rdata_i;
               st_next.fsm = S_EXEC;
               st_next.req = 1'b0;
            end
         end
         S_EXEC: begin
            st_next.addr = st_reg.ins.ea;
            case (st_reg.ins.op)
               OP_XOR_HALF: begin
                  case (st_reg.ins.mode)
                     M_LEFT: newa = {st_reg.a[31:16] ^ op16, st_reg.a[15:0]};
                     M_RIGHT: newa = {st_reg.a[31:16], st_reg.a[15:0] ^ op16};
                     default: newa = st_reg.a ^ {{16{op16[15]}}, op16};
                  endcase
                  st_next.a = newa;
                  if (st_reg.ins.cen) begin
                     st_next.cc = cc_logic({32'h0, newa}, 1'b0);
                  end
               end
               OP_XOR_BYTE: begin
                  newa = st_reg.a ^ ({op8, 24'h0} >> {st_reg.ins.mode, 3'b000});
                  st_next.a = newa;
                  if (st_reg.ins.cen) begin
                     st_next.cc = cc_logic({32'h0, newa}, 1'b0);
                  end
               end
               OP_XOR_STOR: begin
                  r64 = acc64 ^ mem64;
                  if (st_reg.ins.cen) begin
                     st_next.cc = cc_logic(r64, dbl);
                  end
                  st_next.wdata = dbl ? r64[63:32] : r64[31:0];
                  st_next.wd1 = r64[31:0];
                  st_next.wa1 = st_reg.ins.ea + WORD_STEP;
                  st_next.wr2 = dbl;
                  st_next.fsm = S_WR0;
               end
               OP_COMPL: begin
                  r64 = ~(st_reg.ins.mode == M_MEM ? {32'h0, st_reg.m0} : acc64);
                  if (st_reg.ins.cen) begin
                     st_next.cc = cc_logic(r64, dbl);
                  end
                  if (st_reg.ins.mode == M_A || st_reg.ins.mode == M_D) begin
                     st_next.a = ~st_reg.a;
                  end
                  if (st_reg.ins.mode == M_MEM) begin
                     st_next.wdata = r64[31:0];
                     st_next.fsm = S_WR0;
                  end else if (st_reg.ins.mode[1]) begin
                     st_next.addr = B_ACC_ADDR;
                     st_next.wdata = ~st_reg.b;
                     st_next.fsm = S_WR0;
                  end
               end
               OP_CMP_AND: begin
                  r64 = acc64 & opd64;
                  st_next.cc = (r64 == opd64) ? CC_ONE : (r64 == 64'h0) ? CC_TWO : CC_THREE;
               end
               OP_CMP_WORD: st_next.cc = cmp_u(acc64, opd64);
               OP_CMP_HALF: st_next.cc = cmp_u({48'h0, ahalf}, {48'h0, op16});
               OP_CMP_BYTE: begin
                  st_next.cc = cmp_u({56'h0, byte_of(st_reg.a, st_reg.ins.mode)},
                     {56'h0, op8});
               end
               default: st_next.cc = st_reg.cc;
            endcase
            if (st_next.fsm == S_WR0) begin
               st_next.req = 1'b1;
               st_next.we = 1'b1;
            end else begin
               st_next.fsm = S_IDLE;
               st_next.busy = 1'b0;
               st_next.done = 1'b1;
            end
         end
         S_WR0: begin
            if (mem_ack_i) begin
               if (st_reg.wr2) begin
                  st_next.fsm = S_WR1;
                  st_next.addr = st_reg.wa1;
                  st_next.wdata = st_reg.wd1;
               end else begin
                  st_next.fsm = S_IDLE;
                  st_next.req = 1'b0;
                  st_next.we = 1'b0;
                  st_next.busy = 1'b0;
                  st_next.done = 1'b1;
               end
            end
         end
         S_WR1: begin
            if (mem_ack_i) begin
               st_next.fsm = S_IDLE;
               st_next.req = 1'b0;
               st_next.we = 1'b0;
               st_next.busy = 1'b0;
               st_next.done = 1'b1;
            end
         end
         default: st_next = LCX_STATE_RST;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_reg <= LCX_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign mem_req_o = st_reg.req;
   assign mem_we_o = st_reg.we;
   assign mem_addr_o = st_reg.addr;
   assign mem_wdata_o = st_reg.wdata;
   assign acc_a_o = st_reg.a;
   assign cc_o = st_reg.cc;
   assign busy_o = st_reg.busy;
   assign done_o = st_reg.done;

   // ********************************
   // assertions
   // ********************************
   logic in_exec;
   assign in_exec = (st_reg.fsm == S_EXEC);

   sequence s_dbl_first;
      (st_reg.fsm == S_RD_M0) && mem_ack_i && dbl;
   endsequence

   nop_cmp_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (st_reg.fsm == S_IDLE) && start_i && !instr_i.cen && (instr_i.op == OP_CMP_WORD)
      |=> done_o && !busy_o && (cc_o == $past(cc_o)))
      else $error("compare with enable clear changed state");
   xh_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      in_exec && (st_reg.ins.op == OP_XOR_HALF) && (st_reg.ins.mode == M_LEFT)
      |=> acc_a_o[15:0] == $past(acc_a_o[15:0]))
      else $error("half xor touched right half");
   xb_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      in_exec && (st_reg.ins.op == OP_XOR_BYTE) && (st_reg.ins.mode == 2'h0)
      |=> acc_a_o[23:0] == $past(acc_a_o[23:0]))
      else $error("byte xor touched other bytes");
   xs_acc_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      in_exec && (st_reg.ins.op == OP_XOR_STOR)
      |=> mem_req_o && mem_we_o && (mem_addr_o == $past(st_reg.ins.ea))
      && (acc_a_o == $past(acc_a_o)))
      else $error("xor to storage write wrong");
   ca_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      in_exec && (st_reg.ins.op == OP_CMP_AND) |=> (acc_a_o == $past(acc_a_o)) && done_o)
      else $error("comparative and altered accumulator");
   cm_flip_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      in_exec && (st_reg.ins.op == OP_COMPL) && (st_reg.ins.mode == M_A)
      |=> acc_a_o == ~$past(acc_a_o))
      else $error("complement of A wrong");
   dbl_fetch_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      s_dbl_first |=> (st_reg.fsm == S_RD_M1) && mem_req_o && !mem_we_o
      && (mem_addr_o == st_reg.ins.ea + WORD_STEP))
      else $error("second word fetch wrong");
   ch_eq_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      in_exec && (st_reg.ins.op == OP_CMP_HALF) && (ahalf == op16) |=> cc_o == CC_TWO)
      else $error("half compare equal code wrong");

endmodule

// ===== tb/lcx_mem_model.sv
// storage partner model with adjustable answer delay
`timescale 1ns/100ps
module lcx_mem_model (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [17:0] mem_addr_i,
   input wire logic [31:0] mem_wdata_i,
   input wire logic [1:0] delay_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o
);
   logic [31:0] mem [64];
   logic [1:0] cnt_reg;

   // one ack per request, read data scrambled outside the ack cycle
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mem_ack_o <= 1'b0;
         cnt_reg <= 2'h0;
         mem_rdata_o <= 32'h5a5a_a5a5;
      end else if (mem_ack_o || !mem_req_i) begin
         mem_ack_o <= 1'b0;
         cnt_reg <= 2'h0;
         mem_rdata_o <= ~mem_rdata_o;
      end else if (cnt_reg < delay_i) begin
         cnt_reg <= cnt_reg + 2'h1;
         mem_rdata_o <= ~mem_rdata_o;
      end else begin
         mem_ack_o <= 1'b1;
         if (mem_we_i) mem[mem_addr_i[7:2]] <= mem_wdata_i;
         else mem_rdata_o <= mem[mem_addr_i[7:2]];
      end
   end
endmodule

// ===== tb/tb.sv
// self-checking bench for the logical and compare unit
`timescale 1ns/100ps
module tb
   import lcx_pkg::*;
;
   logic mclk_i, reset_i, start_i, mem_ack_i, mem_req_o, mem_we_o, busy_o, done_o;
   lcx_instr_t instr_i;
   logic [31:0] mem_rdata_i, mem_wdata_o, acc_a_o, ra, seed;
   logic [31:0] sm [64];
   logic [17:0] mem_addr_o;
   logic [1:0] cc_o, dly, rcc;
   int n_errors, tests_run;
   localparam logic [7:0] OPS [8] = '{OP_XOR_HALF, OP_XOR_BYTE, OP_XOR_STOR, OP_COMPL,
      OP_CMP_AND, OP_CMP_WORD, OP_CMP_HALF, OP_CMP_BYTE};

   lcx_exec_unit i_lcx_exec_unit (.mclk_i(mclk_i), .reset_i(reset_i), .start_i(start_i),
      .instr_i(instr_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .acc_a_o(acc_a_o), .cc_o(cc_o), .busy_o(busy_o),
      .done_o(done_o));
   lcx_mem_model i_lcx_mem_model (.mclk_i(mclk_i), .reset_i(reset_i), .mem_req_i(mem_req_o),
      .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .delay_i(dly), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

   always #12.5 mclk_i = ~mclk_i;

   // ********************************
   // expectation helpers
   // ********************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function logic [17:0] rea();
      logic [31:0] t;
      t = rnd();
      return 18'h20 + {11'h0, t[4:0], 2'b00};
   endfunction

   function automatic logic [1:0] lcc(input logic [63:0] v, input logic d);
      logic [63:0] m;
      m = d ? '1 : 64'hffff_ffff;
      return ((v & m) == m) ? CC_ONE : ((v & m) == 0) ? CC_TWO : CC_THREE;
   endfunction

   function automatic logic [1:0] ucmp(input logic [63:0] a, b);
      return (a < b) ? CC_ONE : (a == b) ? CC_TWO : CC_THREE;
   endfunction

   function automatic bit is_nop(input logic [7:0] op, input logic [1:0] md, input logic c, l);
      case (op)
         OP_XOR_HALF: return md == M_MEM;
         OP_XOR_BYTE, OP_COMPL: return 1'b0;
         OP_XOR_STOR: return l || md == M_MEM;
         OP_CMP_HALF: return !c || md == M_MEM || md == M_RIGHT_SX;
         default: return !c || (md == M_MEM && op != OP_CMP_BYTE);
      endcase
   endfunction

   task automatic predict(input logic [7:0] op, input logic [1:0] md, input logic c, l,
      input logic [17:0] f, e);
      logic [63:0] sx, acc, mv, r;
      logic [15:0] h;
      logic [7:0] y;
      int x;
      logic d;
      x = e[7:2];
      d = (md == M_D);
      sx = {{46{f[17]}}, f};
      acc = d ? {ra, sm[4]} : (md == M_B) ? sm[4] : ra;
      mv = d ? {sm[x], sm[x + 1]} : sm[x];
      if (l) mv = d ? sx : sx[31:0];
      h = l ? f[15:0] : sm[x][15:0];
      y = l ? f[7:0] : sm[x][7:0];
      case (op)
         OP_XOR_HALF: if (md != M_MEM) begin
            if (md == M_LEFT) ra[31:16] ^= h;
            else if (md == M_RIGHT) ra[15:0] ^= h;
            else ra ^= {{16{h[15]}}, h};
            if (c) rcc = lcc(ra, 0);
         end
         OP_XOR_BYTE: begin
            ra[31 - 8 * md -: 8] ^= y;
            if (c) rcc = lcc(ra, 0);
         end
         OP_XOR_STOR: if (!l && md != M_MEM) begin
            r = acc ^ mv;
            if (d) sm[x] = r[63:32];
            sm[x + d] = r[31:0];
            if (c) rcc = lcc(r, d);
         end
         OP_COMPL: begin
            if (md == M_MEM) sm[x] = ~sm[x];
            if (md == M_A || md == M_D) ra = ~ra;
            if (md == M_B || md == M_D) sm[4] = ~sm[4];
            r = d ? {ra, sm[4]} : (md == M_B) ? sm[4] : (md == M_A) ? ra : sm[x];
            if (c) rcc = lcc(r, d);
         end
         OP_CMP_AND: if (c && md != M_MEM) begin
            r = mv & acc;
            rcc = (r == mv) ? CC_ONE : (r == 0) ? CC_TWO : CC_THREE;
         end
         OP_CMP_WORD: if (c && md != M_MEM) rcc = ucmp(acc, mv);
         OP_CMP_HALF: if (c && (md == M_LEFT || md == M_RIGHT))
            rcc = ucmp((md == M_LEFT) ? ra[31:16] : ra[15:0], h);
         OP_CMP_BYTE: if (c) rcc = ucmp(ra[31 - 8 * md -: 8], y);
         default: ;
      endcase
   endtask

   task automatic chk(input logic [63:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic poke(input logic [5:0] x, input logic [31:0] v);
      sm[x] = v;
      i_lcx_mem_model.mem[x] = v;
   endtask

   task automatic run(input logic [7:0] op, input logic [1:0] md, input logic c, l,
      input logic [17:0] f, e, input bit dup = 0);
      int k;
      predict(op, md, c, l, f, e);
      @(posedge mclk_i);
      dly <= seed[9:8];
      start_i <= 1'b1;
      instr_i <= '{op, md, c, l, f, e};
      @(posedge mclk_i);
      if (dup) begin
         instr_i.op <= OP_COMPL;
         instr_i.mode <= M_A;
         @(posedge mclk_i);
      end
      start_i <= 1'b0;
      k = 0;
      #1;
      chk(busy_o, !is_nop(op, md, c, l));
      while (done_o !== 1'b1 && k < 200) begin
         @(posedge mclk_i);
         #1;
         k++;
      end
      chk(done_o, 1'b1);
      chk(busy_o, 1'b0);
      chk(acc_a_o, ra);
      chk(cc_o, rcc);
      for (int i = 0; i < 64; i++) chk(i_lcx_mem_model.mem[i], sm[i]);
   endtask

   task automatic set_a(input logic [31:0] v);
      run(OP_XOR_HALF, M_LEFT, 0, 1, {2'b00, ra[31:16] ^ v[31:16]}, 18'h20);
      run(OP_XOR_HALF, M_RIGHT, 0, 1, {2'b00, ra[15:0] ^ v[15:0]}, 18'h20);
   endtask

   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ********************************
   // scenarios
   // ********************************
   initial begin
      #500000;
      n_errors++;
      stop_test();
   end

   initial begin
      logic [17:0] e;
      logic [31:0] t;
      mclk_i = 0;
      reset_i = 1;
      start_i = 0;
      instr_i = '0;
      dly = 0;
      seed = 32'h371c;
      ra = 0;
      rcc = CC_RESET;
      n_errors = 0;
      tests_run = 0;
      for (int i = 0; i < 64; i++) poke(6'(i), rnd());
      repeat (12) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk(acc_a_o, 32'h0);
      chk(cc_o, CC_RESET);
      for (int m = 0; m < 4; m++) begin
         for (int l = 0; l < 2; l++) run(OP_XOR_HALF, 2'(m), 1, 1'(l), 18'(rnd()), rea());
         for (int l = 0; l < 2; l++) run(OP_XOR_BYTE, 2'(m), 1, 1'(l), 18'(rnd()), rea());
         run(OP_XOR_STOR, 2'(m), 1, 0, 18'h0, rea());
         run(OP_COMPL, 2'(m), 1, 1, 18'(rnd()), rea());
         run(OP_CMP_AND, 2'(m), 1, 1, 18'h20000 | 18'(rnd()), rea());
         run(OP_CMP_WORD, 2'(m), 1, 1, 18'h3ffff, rea());
         run(OP_CMP_HALF, 2'(m), 1, 1, 18'(rnd()), rea());
      end
      run(OP_XOR_HALF, M_RIGHT, 0, 1, 18'(rnd()), rea());
      run(OP_XOR_STOR, M_A, 1, 1, 18'h0, rea());
      e = rea();
      poke(e[7:2], ra);
      run(OP_XOR_STOR, M_A, 1, 0, 18'h0, e);
      set_a(32'h0);
      run(OP_COMPL, M_A, 1, 0, 18'h0, 18'h0);
      run(OP_COMPL, M_A, 1, 0, 18'h0, 18'h0);
      set_a(rnd());
      for (int j = 0; j < 3; j++) begin
         e = rea();
         t = rnd();
         poke(e[7:2], (j == 0) ? (ra & t) : (j == 1) ? ~ra : t);
         run(OP_CMP_AND, M_A, 1, 0, 18'h0, e);
      end
      run(OP_CMP_AND, M_A, 0, 0, 18'h0, rea());
      set_a(32'h8000_0000);
      run(OP_XOR_STOR, M_A, 1, 0, 18'h0, rea(), 1);
      for (int j = -1; j < 3; j++) begin
         e = rea();
         poke(e[7:2], (j == 2) ? 32'h1 : ra + 32'(j));
         run(OP_CMP_WORD, M_A, 1, 0, 18'h0, e);
      end
      run(OP_CMP_WORD, M_B, 0, 0, 18'h0, rea());
      e = rea();
      poke(e[7:2], {16'h0, ra[31:16]});
      run(OP_CMP_HALF, M_LEFT, 1, 0, 18'h0, e);
      run(OP_CMP_HALF, M_RIGHT, 1, 0, 18'h0, e);
      for (int m = 0; m < 4; m++) begin
         run(OP_CMP_BYTE, 2'(m), 1, 1, {10'h0, ra[31 - 8 * m -: 8]}, rea());
         run(OP_CMP_BYTE, 2'(m), 1, 0, 18'h0, rea());
      end
      repeat (60) begin
         t = rnd();
         poke(t[13:8], rnd());
         run(OPS[t[2:0]], t[4:3], t[5], t[6], 18'(rnd()), rea());
      end
      stop_test();
   end
endmodule
